// [bench/mcr_misc_regs_checker.sv]
`timescale 1ns/1ps
`default_nettype none
`include "mcr_consts.svh"

// Port-level relations of the register bank
module mcr_misc_regs_checker (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // Register outputs
  input wire logic timer_clock_off,
  input wire logic [`MCR_KEY_W-1:0] cipher_key_ptr,
  input wire logic ref_ext_sel,
  input wire logic ref_int_level,
  input wire logic ref_level_2v048,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  // Pin ownership
  input wire logic pin_in_en,
  input wire logic pin_out_en,
  input wire logic pin_out_n_en,
  input wire logic tmr_owns_in,
  input wire logic tmr_owns_out,
  input wire logic tmr_owns_out_n,
  // Timer access
  input wire logic tmr_req_valid,
  input wire logic tmr_sel,
  input wire logic tmr_resp_valid,
  input wire logic tmr_resp_blocked
);
  // Pin enables as one vector, so $past sees a single signal
  logic [2:0] own_pin;
  logic lvl_exp;
  assign own_pin = {pin_in_en, pin_out_en, pin_out_n_en};
  assign lvl_exp = ref_int_level & !ref_ext_sel;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_rst;
    $rose(aresetn) |-> timer_clock_off && cipher_key_ptr == 16'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset value");
  // Gate is the registered bit, so the refusal comes one cycle after the request
  property p_block;
    tmr_req_valid && clk_en && timer_clock_off
      |=> tmr_resp_valid && tmr_resp_blocked;
  endproperty
  a_block: assert property (p_block) else $error("not blocked");
  property p_nosel;
    tmr_sel |-> !$past(timer_clock_off);
  endproperty
  a_nosel: assert property (p_nosel) else $error("gated select");
  property p_pass;
    tmr_req_valid && clk_en && !timer_clock_off
      |=> tmr_sel ##1 tmr_resp_valid && !tmr_resp_blocked;
  endproperty
  a_pass: assert property (p_pass) else $error("access lost");
  // Ownership follows the gate bit as it now stands, never a stale one
  property p_own;
    clk_en |=> {tmr_owns_in, tmr_owns_out, tmr_owns_out_n} ==
      ($past(own_pin) & {3{!timer_clock_off}});
  endproperty
  a_own: assert property (p_own) else $error("pin owner wrong");
  // Applied level always agrees with the two stored bits
  property p_lvl;
    ref_level_2v048 == lvl_exp;
  endproperty
  a_lvl: assert property (p_lvl) else $error("level wrong");
  // Key only moves with a completed write
  property p_key;
    $changed(cipher_key_ptr) |-> $rose(s_axi_bvalid);
  endproperty
  a_key: assert property (p_key) else $error("key moved");
  property p_rtop;
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0;
  endproperty
  a_rtop: assert property (p_rtop) else $error("upper bits set");

  c_blk: cover property (tmr_resp_valid && tmr_resp_blocked);
  c_pass: cover property (tmr_resp_valid && !tmr_resp_blocked);
  c_wr: cover property ($rose(s_axi_bvalid));
endmodule

bind mcr_misc_regs mcr_misc_regs_checker u_mcr_misc_regs_checker (
  .aclk, .aresetn, .clk_en, .timer_clock_off, .cipher_key_ptr,
  .ref_ext_sel, .ref_int_level, .ref_level_2v048, .s_axi_bvalid,
  .s_axi_rvalid, .s_axi_rdata, .pin_in_en, .pin_out_en, .pin_out_n_en,
  .tmr_owns_in, .tmr_owns_out, .tmr_owns_out_n, .tmr_req_valid, .tmr_sel,
  .tmr_resp_valid, .tmr_resp_blocked
);
`default_nettype wire

// [bench/mcr_misc_regs_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module mcr_misc_regs_tb;
  // Row: write, expected responses, read-back and control outputs
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
    logic [3:0] s;
    logic [1:0] rsp;
    logic [31:0] rd;
    logic [20:0] o;
  } mcr_row_t;
  localparam mcr_row_t rows [8] = '{
    '{8'h24, 32'hffffffff, 4'hf, 2'h0, 32'h1, 21'h100000},
    '{8'h24, 32'h0, 4'hf, 2'h0, 32'h0, 21'h0},
    '{8'h34, 32'hdeadbeef, 4'hf, 2'h0, 32'hbeef, 21'h0beef},
    '{8'h34, 32'h12345678, 4'h1, 2'h0, 32'hbe78, 21'h0be78},
    // External reference rows choose no analog input zero, pin set up first
    '{8'h38, 32'hffffffff, 4'hf, 2'h0, 32'hd, 21'h0ebe78},
    '{8'h38, 32'h8, 4'h1, 2'h0, 32'h8, 21'h09be78},
    '{8'h38, 32'hffffffff, 4'h2, 2'h0, 32'h8, 21'h09be78},
    '{8'h30, 32'hffffffff, 4'hf, 2'h2, 32'h0, 21'h09be78}};
  logic aclk, aresetn, clk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, timer_clock_off;
  logic tmr_clk_en, ref_ext_sel, ref_int_level, ref_level_2v048;
  logic sleep_ext_clock_enable, pin_in_en, pin_out_en, pin_out_n_en;
  logic tmr_owns_in, tmr_owns_out, tmr_owns_out_n, tmr_req_valid;
  logic tmr_req_write, tmr_resp_valid, tmr_resp_blocked;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp, brsp;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [3:0] s_axi_wstrb;
  logic [7:0] s_axi_awaddr, s_axi_araddr, tmr_req_addr, tmr_addr;
  logic tmr_sel, tmr_write;
  logic [20:0] outs;
  logic [15:0] cipher_key_ptr;
  logic [31:0] s_axi_wdata, s_axi_rdata, tmr_req_wdata, tmr_resp_rdata;
  logic [31:0] tmr_rdata, rd, tmr_wdata;
  logic [32:0] tr;
  int miscompares, checks_done, sels;

  mcr_misc_regs u_mcr_misc_regs (
    .aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .timer_clock_off, .tmr_clk_en, .cipher_key_ptr,
    .ref_ext_sel, .ref_int_level, .ref_level_2v048, .sleep_ext_clock_enable,
    .pin_in_en, .pin_out_en, .pin_out_n_en, .tmr_owns_in, .tmr_owns_out,
    .tmr_owns_out_n, .tmr_req_valid, .tmr_req_write, .tmr_req_addr,
    .tmr_req_wdata, .tmr_resp_valid, .tmr_resp_blocked, .tmr_resp_rdata,
    .tmr_sel, .tmr_write, .tmr_addr, .tmr_wdata, .tmr_rdata);

  // Control outputs packed in row order
  assign outs = {timer_clock_off, ref_int_level, ref_ext_sel,
    sleep_ext_clock_enable, ref_level_2v048, cipher_key_ptr};

  // 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Timer selects seen, to prove which requests reached the timer
  always @(posedge aclk) begin
    if (tmr_sel === 1'b1) sels++;
  end

  task automatic chk(input string n, input logic [32:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s exp %h got %h", n, exp, got);
    end
  endtask

  task automatic conclude;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Write: both channels offered together, each dropped when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, logic [3:0] s);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    // Ends on the write response; only the watchdog ends a hung wait
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    brsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // One-cycle timer request; timer data held for the whole access
  task automatic treq(input logic w, input logic [31:0] td);
    @(posedge aclk);
    {tmr_req_valid, tmr_req_write, tmr_req_addr} <= {1'b1, w, 8'h04};
    tmr_req_wdata <= 32'h000000c3;
    tmr_rdata <= td;
    @(posedge aclk);
    tmr_req_valid <= 1'b0;
    do begin
      @(posedge aclk);
    end while (tmr_resp_valid !== 1'b1);
    tr = {tmr_resp_blocked, tmr_resp_rdata};
  endtask

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awprot, s_axi_arprot} = '0;
    {tmr_req_valid, tmr_req_write, tmr_req_addr, tmr_req_wdata} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    tmr_rdata = '0;
    clk_en = 1'b1;
    {pin_in_en, pin_out_en, pin_out_n_en} = 3'h5;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      axw(rows[i].a, rows[i].d, rows[i].s);
      axr(rows[i].a);
      chk("resp", 33'({brsp, rsp}), 33'({2{rows[i].rsp}}));
      chk("rdata", 33'(rd), 33'(rows[i].rd));
      chk("outs", 33'(outs), 33'(rows[i].o));
    end
    // Timer path open, then gated, then open again
    chk("owns", 33'({tmr_owns_in, tmr_owns_out, tmr_owns_out_n}), 33'h5);
    treq(1'b0, 32'h5a5a0001);
    chk("open", tr, 33'h05a5a0001);
    axw(8'h24, 32'h1, 4'h1);
    chk("gated", 33'({tmr_clk_en, tmr_owns_in, tmr_owns_out,
      tmr_owns_out_n}), 33'h0);
    treq(1'b1, 32'h5a5a0002);
    chk("blocked", tr, 33'h100000000);
    // A refused write leaves the timer port as the last read left it
    chk("kept", 33'({tmr_write, tmr_addr, tmr_wdata[7:0]}), 33'h004c3);
    chk("no sel", 33'(sels), 33'd1);
    axw(8'h24, 32'h0, 4'h1);
    treq(1'b0, 32'h5a5a0003);
    chk("resumed", tr, 33'h05a5a0003);
    treq(1'b1, 32'h5a5a0004);
    chk("wr ack", tr, 33'h0);
    chk("fwd", 33'({tmr_write, tmr_addr, tmr_wdata[7:0]}), 33'h104c3);
    chk("sels", 33'(sels), 33'd3);
    // Enable low: a request offered meanwhile is neither seen nor answered
    @(posedge aclk);
    clk_en <= 1'b0;
    tmr_req_valid <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("frozen", 33'({tmr_resp_valid, 32'(sels)}), 33'd3);
    clk_en <= 1'b1;
    tmr_req_valid <= 1'b0;
    // Reset in mid-run restores every field
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    axr(8'h24);
    chk("rst gate", 33'(rd), 33'h1);
    axr(8'h34);
    chk("rst key", 33'(rd), 33'h0);
    axr(8'h38);
    chk("rst ref", 33'(rd), 33'h0);
    conclude();
  end

  // Whole run needs about a hundred cycles
  initial begin
    repeat (3000) @(posedge aclk);
    miscompares++;
    conclude();
  end
endmodule
`default_nettype wire

// [rtl/mcr_consts.svh]
// What this block does
// R1: Gate bit 0 stops timer clock, resets 1
// R2: Gated timer blocks register access, stops working
// R3: Gated timer keeps all register values
// R4: Key pointer 16-bit read/write, upper zero
// R5: Bit 3 picks internal level when internal
// R6: Bit 2 picks external reference, resets 0
// R7: Software avoids analog input zero with external
// R8: Software sets reference pin function first
// R9: Bit 0 keeps sleep clock input running
// R10: Timer owns pins only when enabled, ungated
// R11: Reserved bits ignore writes, read zero
`ifndef MCR_CONSTS_SVH
`define MCR_CONSTS_SVH

// Register byte offsets
`define MCR_OFF_CLKGATE 8'h24
`define MCR_OFF_KEYPTR 8'h34
`define MCR_OFF_REFCFG 8'h38

// Field positions
`define MCR_BIT_CLKOFF 0
`define MCR_BIT_INTREF 3
`define MCR_BIT_EXTREF 2
`define MCR_BIT_SLPCLK 0

// Widths
`define MCR_ADDR_W 8
`define MCR_KEY_W 16

// Reset values
`define MCR_RST_CLKOFF 1'b1
`define MCR_RST_KEYPTR 16'h0000
`define MCR_RST_INTREF 1'b0
`define MCR_RST_EXTREF 1'b0
`define MCR_RST_SLPCLK 1'b0

// Bus responses
`define MCR_RESP_OKAY 2'b00
`define MCR_RESP_SLVERR 2'b10

`endif

// [rtl/mcr_misc_regs.sv]
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "mcr_consts.svh"

module mcr_misc_regs (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // AXI4-Lite write address
  input wire logic [`MCR_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [`MCR_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Controls to the rest of the chip
  output logic timer_clock_off,
  output logic tmr_clk_en,
  output logic [`MCR_KEY_W-1:0] cipher_key_ptr,
  output logic ref_ext_sel,
  output logic ref_int_level,
  output logic ref_level_2v048,
  output logic sleep_ext_clock_enable,
  // Timer pin ownership
  input wire logic pin_in_en,
  input wire logic pin_out_en,
  input wire logic pin_out_n_en,
  output logic tmr_owns_in,
  output logic tmr_owns_out,
  output logic tmr_owns_out_n,
  // System-side access to timer registers
  input wire logic tmr_req_valid,
  input wire logic tmr_req_write,
  input wire logic [`MCR_ADDR_W-1:0] tmr_req_addr,
  input wire logic [31:0] tmr_req_wdata,
  output logic tmr_resp_valid,
  output logic tmr_resp_blocked,
  output logic [31:0] tmr_resp_rdata,
  // Low-power timer register port
  output logic tmr_sel,
  output logic tmr_write,
  output logic [`MCR_ADDR_W-1:0] tmr_addr,
  output logic [31:0] tmr_wdata,
  input wire logic [31:0] tmr_rdata
);
  import mcr_pkg::*;

  // Reset image: bus idle with readies up, fields at documented values
  localparam mcr_regs_st_t RST = '{
    awready: 1'b1,
    wready: 1'b1,
    bvalid: 1'b0,
    bresp: `MCR_RESP_OKAY,
    arready: 1'b1,
    rvalid: 1'b0,
    rresp: `MCR_RESP_OKAY,
    rdata: 32'h0000_0000,
    have_aw: 1'b0,
    have_w: 1'b0,
    awaddr: 8'h00,
    wdata: 32'h0000_0000,
    wstrb: 4'h0,
    clk_off: `MCR_RST_CLKOFF,
    key_ptr: `MCR_RST_KEYPTR,
    int_ref: `MCR_RST_INTREF,
    ext_ref: `MCR_RST_EXTREF,
    slp_clk: `MCR_RST_SLPCLK,
    ref_level_hi: 1'b0,
    tmr_clk_en: ~`MCR_RST_CLKOFF,
    own_in: 1'b0,
    own_out: 1'b0,
    own_out_n: 1'b0
  };

  mcr_regs_st_t q_r; // Current state
  mcr_regs_st_t q_nxt; // Next state

  // Read image of one register; reserved bits are built as zero
  function automatic logic [31:0] read_word(
    input logic [`MCR_ADDR_W-1:0] addr,
    input mcr_regs_st_t s
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    case (addr)
      `MCR_OFF_CLKGATE: begin
        w[`MCR_BIT_CLKOFF] = s.clk_off; // R11
      end
      `MCR_OFF_KEYPTR: begin
        w[`MCR_KEY_W-1:0] = s.key_ptr; // R4
      end
      `MCR_OFF_REFCFG: begin
        w[`MCR_BIT_INTREF] = s.int_ref;
        w[`MCR_BIT_EXTREF] = s.ext_ref;
        w[`MCR_BIT_SLPCLK] = s.slp_clk; // R11
      end
      default: begin
        w = 32'h0000_0000;
      end
    endcase
    return w;
  endfunction

  // True for the three mapped offsets
  function automatic logic is_mapped(input logic [`MCR_ADDR_W-1:0] addr);
    logic hit;
    hit = (addr == `MCR_OFF_CLKGATE) || (addr == `MCR_OFF_KEYPTR) ||
      (addr == `MCR_OFF_REFCFG);
    return hit;
  endfunction

  // Bus handshakes, register writes and derived controls
  always_comb begin
    q_nxt = q_r;
    // Address and data are caught independently, in either order
    if (q_r.awready && s_axi_awvalid) begin
      q_nxt.have_aw = 1'b1;
      q_nxt.awaddr = s_axi_awaddr;
      q_nxt.awready = 1'b0;
    end
    if (q_r.wready && s_axi_wvalid) begin
      q_nxt.have_w = 1'b1;
      q_nxt.wdata = s_axi_wdata;
      q_nxt.wstrb = s_axi_wstrb;
      q_nxt.wready = 1'b0;
    end
    // Both halves held: commit once, then answer
    if (q_r.have_aw && q_r.have_w && !q_r.bvalid) begin
      q_nxt.have_aw = 1'b0;
      q_nxt.have_w = 1'b0;
      q_nxt.bvalid = 1'b1;
      q_nxt.bresp = is_mapped(q_r.awaddr) ? `MCR_RESP_OKAY :
        `MCR_RESP_SLVERR;
      case (q_r.awaddr)
        `MCR_OFF_CLKGATE: begin
          // Only bit 0 is stored; other bits are dropped
          if (q_r.wstrb[0]) begin
            q_nxt.clk_off = q_r.wdata[`MCR_BIT_CLKOFF]; // R1
          end
        end
        `MCR_OFF_KEYPTR: begin
          // Byte lanes 0 and 1 carry the pointer
          if (q_r.wstrb[0]) begin
            q_nxt.key_ptr[7:0] = q_r.wdata[7:0]; // R4
          end
          if (q_r.wstrb[1]) begin
            q_nxt.key_ptr[15:8] = q_r.wdata[15:8]; // R4
          end
        end
        `MCR_OFF_REFCFG: begin
          if (q_r.wstrb[0]) begin
            q_nxt.int_ref = q_r.wdata[`MCR_BIT_INTREF]; // R5
            q_nxt.ext_ref = q_r.wdata[`MCR_BIT_EXTREF]; // R6
            q_nxt.slp_clk = q_r.wdata[`MCR_BIT_SLPCLK]; // R9
          end
        end
        default: begin
          // Unmapped: nothing stored, error answered
          q_nxt.bresp = `MCR_RESP_SLVERR;
        end
      endcase
    end
    // Response taken: reopen both write channels
    if (q_r.bvalid && s_axi_bready) begin
      q_nxt.bvalid = 1'b0;
      q_nxt.awready = 1'b1;
      q_nxt.wready = 1'b1;
    end
    // Read answered from the registers as they stand this cycle
    if (q_r.arready && s_axi_arvalid) begin
      q_nxt.arready = 1'b0;
      q_nxt.rvalid = 1'b1;
      q_nxt.rdata = read_word(s_axi_araddr, q_r);
      q_nxt.rresp = is_mapped(s_axi_araddr) ? `MCR_RESP_OKAY :
        `MCR_RESP_SLVERR;
    end
    if (q_r.rvalid && s_axi_rready) begin
      q_nxt.rvalid = 1'b0;
      q_nxt.arready = 1'b1;
    end
    // Internal level only counts while internal source is chosen
    q_nxt.ref_level_hi = q_nxt.int_ref & ~q_nxt.ext_ref; // R5
    // Gate stops the timer clock; contents simply wait
    q_nxt.tmr_clk_en = ~q_nxt.clk_off; // R2 R3
    // Timer keeps a pin only while ungated, else GPIO keeps it
    q_nxt.own_in = pin_in_en & ~q_nxt.clk_off; // R10
    q_nxt.own_out = pin_out_en & ~q_nxt.clk_off; // R10
    q_nxt.own_out_n = pin_out_n_en & ~q_nxt.clk_off; // R10
  end

  // State register, frozen while the enable is low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_r <= RST;
    end else if (clk_en) begin
      q_r <= q_nxt;
    end
  end

  // Timer register access passes only while the clock runs
  mcr_tmr_gate u_gate (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .clk_off(q_r.clk_off),
    .req_valid(tmr_req_valid),
    .req_write(tmr_req_write),
    .req_addr(tmr_req_addr),
    .req_wdata(tmr_req_wdata),
    .tgt_sel(tmr_sel),
    .tgt_write(tmr_write),
    .tgt_addr(tmr_addr),
    .tgt_wdata(tmr_wdata),
    .tmr_rdata(tmr_rdata),
    .resp_valid(tmr_resp_valid),
    .resp_blocked(tmr_resp_blocked),
    .resp_rdata(tmr_resp_rdata)
  );

  // Bus outputs
  assign s_axi_awready = q_r.awready;
  assign s_axi_wready = q_r.wready;
  assign s_axi_bresp = q_r.bresp;
  assign s_axi_bvalid = q_r.bvalid;
  assign s_axi_arready = q_r.arready;
  assign s_axi_rdata = q_r.rdata;
  assign s_axi_rresp = q_r.rresp;
  assign s_axi_rvalid = q_r.rvalid;

  // Control outputs
  assign timer_clock_off = q_r.clk_off;
  assign tmr_clk_en = q_r.tmr_clk_en;
  assign cipher_key_ptr = q_r.key_ptr;
  assign ref_ext_sel = q_r.ext_ref;
  assign ref_int_level = q_r.int_ref;
  assign ref_level_2v048 = q_r.ref_level_hi;
  assign sleep_ext_clock_enable = q_r.slp_clk;
  assign tmr_owns_in = q_r.own_in;
  assign tmr_owns_out = q_r.own_out;
  assign tmr_owns_out_n = q_r.own_out_n;

endmodule
`default_nettype wire

// [rtl/mcr_pkg.sv]
`default_nettype none
`include "mcr_consts.svh"

package mcr_pkg;

  // Whole state of the register bank
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic have_aw;
    logic have_w;
    logic [`MCR_ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic clk_off;
    logic [`MCR_KEY_W-1:0] key_ptr;
    logic int_ref;
    logic ext_ref;
    logic slp_clk;
    logic ref_level_hi;
    logic tmr_clk_en;
    logic own_in;
    logic own_out;
    logic own_out_n;
  } mcr_regs_st_t;

  // Whole state of the timer access gate
  typedef struct packed {
    logic tgt_sel;
    logic tgt_write;
    logic [`MCR_ADDR_W-1:0] tgt_addr;
    logic [31:0] tgt_wdata;
    logic pend;
    logic pend_wr;
    logic resp_valid;
    logic resp_blocked;
    logic [31:0] resp_rdata;
  } mcr_gate_st_t;

endpackage
`default_nettype wire

// [rtl/mcr_tmr_gate.sv]
`timescale 1ns/1ps
`default_nettype none
`include "mcr_consts.svh"

module mcr_tmr_gate (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // Gate state from the bank
  input wire logic clk_off,
  // Requests from the system side
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [`MCR_ADDR_W-1:0] req_addr,
  input wire logic [31:0] req_wdata,
  // Timer register port
  output logic tgt_sel,
  output logic tgt_write,
  output logic [`MCR_ADDR_W-1:0] tgt_addr,
  output logic [31:0] tgt_wdata,
  input wire logic [31:0] tmr_rdata,
  // Answer to the system side
  output logic resp_valid,
  output logic resp_blocked,
  output logic [31:0] resp_rdata
);
  import mcr_pkg::*;

  // Idle gate after reset
  localparam mcr_gate_st_t RST = '0;

  mcr_gate_st_t q_r; // Current state
  mcr_gate_st_t q_nxt; // Next state

  // Forward or refuse one access; a timer read answers a cycle later
  always_comb begin
    q_nxt = q_r;
    q_nxt.tgt_sel = 1'b0;
    q_nxt.resp_valid = 1'b0;
    if (q_r.pend) begin
      // Timer data is taken in the same cycle as its select
      q_nxt.pend = 1'b0;
      q_nxt.resp_valid = 1'b1;
      q_nxt.resp_blocked = 1'b0;
      q_nxt.resp_rdata = q_r.pend_wr ? 32'h0000_0000 : tmr_rdata;
    end
    if (req_valid) begin
      if (clk_off) begin
        // Refused: timer never sees it, so its contents stay put
        q_nxt.resp_valid = 1'b1; // R2
        q_nxt.resp_blocked = 1'b1; // R2
        q_nxt.resp_rdata = 32'h0000_0000; // R3
      end else begin
        q_nxt.tgt_sel = 1'b1;
        q_nxt.tgt_write = req_write;
        q_nxt.tgt_addr = req_addr;
        q_nxt.tgt_wdata = req_wdata;
        q_nxt.pend = 1'b1;
        q_nxt.pend_wr = req_write;
      end
    end
  end

  // State register, frozen while the enable is low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_r <= RST;
    end else if (clk_en) begin
      q_r <= q_nxt;
    end
  end

  assign tgt_sel = q_r.tgt_sel;
  assign tgt_write = q_r.tgt_write;
  assign tgt_addr = q_r.tgt_addr;
  assign tgt_wdata = q_r.tgt_wdata;
  assign resp_valid = q_r.resp_valid;
  assign resp_blocked = q_r.resp_blocked;
  assign resp_rdata = q_r.resp_rdata;

endmodule
`default_nettype wire
